/* File: hdl/jtag_tamper_guard.sv */
// test access port security gates, toggle monitor and tamper penalties
`timescale 1ns/1ps
module jtag_tamper_guard #(
   parameter int NUM_GATES = tamper_guard_pkg::NUM_GATES,
   parameter int RESTORE_CYCLES = tamper_guard_pkg::RESTORE_CYCLES
) (
   input wire logic clk_i,
   input wire logic rst_n_i,        // power-on reset
   // register port
   input wire logic [tamper_guard_pkg::ADDR_W-1:0] addr_i,
   input wire logic [tamper_guard_pkg::DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [tamper_guard_pkg::DATA_W-1:0] rdata_o,
   // security context
   input wire logic sw_auth_i,      // writer is authenticated software
   input wire logic boot_nonsec_i,  // boot mode strap, asynchronous
   input wire logic fuse_disable_i, // programmed disable fuse, async
   // external test port pins
   input wire logic tck_i,
   input wire logic tms_i,
   input wire logic tdi_i,
   // gated paths and penalties
   output logic [NUM_GATES-1:0] path_open_o,
   output logic user_tck_o,
   output logic user_tms_o,
   output logic user_tdi_o,
   output logic ir_force_bypass_o,
   output logic fuse_prog_o,
   output logic global_output_tristate_o,
   output logic global_flop_restore_o,
   output logic alert_o,
   output logic irq_o
);
   localparam int DW = tamper_guard_pkg::DATA_W;
   localparam int EW = tamper_guard_pkg::EV_W;
   localparam int RW = tamper_guard_pkg::RESP_W;
   localparam int RC_W = $clog2(RESTORE_CYCLES + 1);
   localparam int BS_W = $clog2(tamper_guard_pkg::BOOT_SETTLE + 1);

   // register state
   logic [NUM_GATES-1:0] gate_ff;   // 1 = path blocked
   logic [RW-1:0] resp_ff;          // configured tamper responses
   logic [EW-1:0] ev_stat_ff;       // sticky events
   logic [EW-1:0] ev_en_ff;         // event enables
   // context
   tamper_guard_pkg::boot_state_t boot_ff;
   logic [BS_W-1:0] settle_ff;      // settling count before capture
   logic [1:0] strap_meta_ff;       // first synchroniser stages
   logic strap_s_ff;                // synchronised boot strap
   logic fuse_s_ff;                 // synchronised disable fuse
   // detector and penalties
   logic alert;                     // sticky alert from the detector
   logic alert_d_ff;                // previous alert for edge finding
   logic [RC_W-1:0] restore_cnt_ff; // restore pulse count
   logic tck_s, tdi_s, tms_s;       // synchronised test pins
   // decoded strobes
   logic wr_gate, wr_fuse, wr_resp, wr_clr, wr_en, wr_pen;
   logic unlock_ok;                 // opening a gate is permitted
   logic open_req;                  // a write asks to open something
   logic refused;                   // that request was not permitted
   logic alert_rise;
   logic penalty_tri, penalty_rst;
   logic [EW-1:0] ev_set;
   logic [NUM_GATES-1:0] nxt_gate;
   logic [DW-1:0] nxt_rdata;

   // one address compare, shared by every decoded strobe
   function automatic logic hit(
      input logic [tamper_guard_pkg::ADDR_W-1:0] a,
      input logic [tamper_guard_pkg::ADDR_W-1:0] ofs
   );
      hit = (a == ofs);
   endfunction : hit

   assign wr_gate = wr_i && hit(addr_i, tamper_guard_pkg::OFS_GATE);
   assign wr_fuse = wr_i && hit(addr_i, tamper_guard_pkg::OFS_FUSE);
   assign wr_resp = wr_i && hit(addr_i, tamper_guard_pkg::OFS_RESP);
   assign wr_clr = wr_i && hit(addr_i, tamper_guard_pkg::OFS_EV_CLR);
   assign wr_en = wr_i && hit(addr_i, tamper_guard_pkg::OFS_EV_EN);
   assign wr_pen = wr_i && hit(addr_i, tamper_guard_pkg::OFS_PEN);

   // strap and fuse synchronisers; first stage feeds only the second
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         strap_meta_ff <= 2'h0;
         strap_s_ff <= 1'b0;
         fuse_s_ff <= 1'b0;
      end else begin
         strap_meta_ff <= {boot_nonsec_i, fuse_disable_i};
         strap_s_ff <= strap_meta_ff[1];
         fuse_s_ff <= strap_meta_ff[0];
      end
   end

   // boot mode is caught once, after the synchroniser has settled;
   // catching it at reset itself would sample a possibly moving strap
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         boot_ff <= tamper_guard_pkg::BOOT_WAIT;
         settle_ff <= '0;
      end else begin
         unique case (boot_ff)
            tamper_guard_pkg::BOOT_WAIT: begin
               if (settle_ff == BS_W'(tamper_guard_pkg::BOOT_SETTLE)) begin
                  boot_ff <= strap_s_ff ? tamper_guard_pkg::BOOT_NONSECURE
                                        : tamper_guard_pkg::BOOT_SECURE;
               end else begin
                  settle_ff <= settle_ff + BS_W'(1);
               end
            end
            tamper_guard_pkg::BOOT_SECURE: begin
               boot_ff <= boot_ff; // held until the next power-on reset
            end
            tamper_guard_pkg::BOOT_NONSECURE: begin
               boot_ff <= boot_ff;
            end
         endcase
      end
   end

   // opening needs a non-secure boot, or authenticated software after a
   // secure boot, and never once the disable fuse is blown
   assign unlock_ok = !fuse_s_ff &&
      (boot_ff == tamper_guard_pkg::BOOT_NONSECURE ||
       (boot_ff == tamper_guard_pkg::BOOT_SECURE && sw_auth_i));

   assign open_req = wr_gate && (|(~wdata_i[NUM_GATES-1:0] & gate_ff));
   assign refused = open_req && !unlock_ok;

   // next gate value: closing is always allowed, opening only when
   // unlocked; the fuse pins every gate shut for good
   always_comb begin
      nxt_gate = gate_ff;
      if (fuse_s_ff) begin
         nxt_gate = {NUM_GATES{1'b1}};
      end else if (wr_gate) begin
         if (unlock_ok) begin
            nxt_gate = wdata_i[NUM_GATES-1:0];
         end else begin
            nxt_gate = gate_ff | wdata_i[NUM_GATES-1:0];
         end
      end
   end

   // gate register; a cleared bit opens the path only from the cycle
   // after the write, so the detector never sees a half-open state
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         gate_ff <= NUM_GATES'(tamper_guard_pkg::GATE_RST);
      end else if (boot_ff == tamper_guard_pkg::BOOT_WAIT) begin
         // a non-secure boot with the disable fuse intact opens every path once
         if (settle_ff == BS_W'(tamper_guard_pkg::BOOT_SETTLE)
             && strap_s_ff && !fuse_s_ff) begin
            gate_ff <= '0;
         end
      end else begin
         gate_ff <= nxt_gate;
      end
   end

   // per-path open levels, registered so each output is a flop
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         path_open_o <= '0;
      end else begin
         path_open_o <= ~gate_ff;
      end
   end

   // toggle detector, held idle while any gate is open
   tck_toggle_detect #(
      .EDGES(tamper_guard_pkg::TOGGLE_EDGES)
   ) u_detect (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .enable_i(&gate_ff),
      .tck_i(tck_i),
      .tdi_i(tdi_i),
      .tms_i(tms_i),
      .tck_s_o(tck_s),
      .tdi_s_o(tdi_s),
      .tms_s_o(tms_s),
      .alert_o(alert) // synchronised to clk_i inside
   );

   // user debug path: forwarded only while both the user and the chain gates are open
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         user_tck_o <= 1'b0;
         user_tms_o <= 1'b0;
         user_tdi_o <= 1'b0;
      end else if (gate_ff[tamper_guard_pkg::GATE_USER]
                   || gate_ff[tamper_guard_pkg::GATE_CHAIN]) begin
         user_tck_o <= 1'b0; // user or chain gate shut, user logic cut off
         user_tms_o <= 1'b0;
         user_tdi_o <= 1'b0;
      end else begin
         user_tck_o <= tck_s;
         user_tms_o <= tms_s;
         user_tdi_o <= tdi_s;
      end
   end

   // fuse effects and fuse programming request
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         ir_force_bypass_o <= 1'b0;
         fuse_prog_o <= 1'b0;
      end else begin
         // every shifted instruction becomes bypass; the tap keeps its
         // id code only for the state after test-logic reset
         ir_force_bypass_o <= fuse_s_ff;
         // one-cycle request to blow the permanent disable fuse
         fuse_prog_o <= wr_fuse
            && wdata_i[tamper_guard_pkg::FUSE_PROG_BIT];
      end
   end

   // tamper response configuration
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         resp_ff <= tamper_guard_pkg::RESP_RST;
      end else if (wr_resp) begin
         resp_ff <= wdata_i[RW-1:0];
      end
   end

   // penalties follow the alert only where a response is configured;
   // otherwise the alert is just recorded
   assign alert_rise = alert && !alert_d_ff;
   assign penalty_tri = (alert && resp_ff[tamper_guard_pkg::RESP_TRI_BIT])
      || (wr_pen && wdata_i[tamper_guard_pkg::PEN_TRI_BIT]);
   assign penalty_rst = (alert_rise
      && resp_ff[tamper_guard_pkg::RESP_RST_BIT])
      || (wr_pen && wdata_i[tamper_guard_pkg::PEN_RST_BIT]);

   // alert copy and edge memory
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         alert_d_ff <= 1'b0;
         alert_o <= 1'b0;
      end else begin
         alert_d_ff <= alert;
         alert_o <= alert;
      end
   end

   // output tri-state lockdown holds until power-on reset, so a leaked
   // pin can never be re-enabled by software after a tamper event
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         global_output_tristate_o <= 1'b0;
      end else if (penalty_tri) begin
         global_output_tristate_o <= 1'b1;
      end
   end

   // fabric flip-flop restore pulse of a fixed length; a new trigger
   // during the pulse restarts it
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         restore_cnt_ff <= '0;
         global_flop_restore_o <= 1'b0;
      end else if (penalty_rst) begin
         restore_cnt_ff <= RC_W'(RESTORE_CYCLES - 1);
         global_flop_restore_o <= 1'b1;
      end else if (restore_cnt_ff != '0) begin
         restore_cnt_ff <= restore_cnt_ff - RC_W'(1);
      end else begin
         global_flop_restore_o <= 1'b0;
      end
   end

   // event sources
   always_comb begin
      ev_set = '0;
      ev_set[tamper_guard_pkg::EV_ALERT] = alert_rise;
      ev_set[tamper_guard_pkg::EV_PENALTY] = penalty_tri || penalty_rst;
      ev_set[tamper_guard_pkg::EV_REFUSED] = refused;
   end

   // sticky events; a set in the clearing cycle wins
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         ev_stat_ff <= tamper_guard_pkg::EV_RST;
      end else begin
         ev_stat_ff <= (ev_stat_ff & ~(wr_clr ? wdata_i[EW-1:0] : '0))
                       | ev_set;
      end
   end

   // event enables
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         ev_en_ff <= '0;
      end else if (wr_en) begin
         ev_en_ff <= wdata_i[EW-1:0];
      end
   end

   // level interrupt, one flop behind the status
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(ev_stat_ff & ev_en_ff);
      end
   end

   // read mux; unmapped and write-only offsets read as zero
   always_comb begin
      nxt_rdata = '0;
      unique case (addr_i)
         tamper_guard_pkg::OFS_GATE: begin
            nxt_rdata[NUM_GATES-1:0] = gate_ff;
         end
         tamper_guard_pkg::OFS_RESP: begin
            nxt_rdata[RW-1:0] = resp_ff;
         end
         tamper_guard_pkg::OFS_STAT: begin
            nxt_rdata[tamper_guard_pkg::STAT_ALERT] = alert;
            nxt_rdata[tamper_guard_pkg::STAT_FUSE] = fuse_s_ff;
            nxt_rdata[tamper_guard_pkg::STAT_NONSEC] =
               (boot_ff == tamper_guard_pkg::BOOT_NONSECURE);
            nxt_rdata[tamper_guard_pkg::STAT_TRI] = global_output_tristate_o;
            nxt_rdata[tamper_guard_pkg::STAT_AUTH] = unlock_ok;
            nxt_rdata[tamper_guard_pkg::STAT_BOOT_DONE] =
               (boot_ff != tamper_guard_pkg::BOOT_WAIT);
            nxt_rdata[tamper_guard_pkg::STAT_GATE_LSB +: NUM_GATES] =
               gate_ff;
         end
         tamper_guard_pkg::OFS_EV_STAT: begin
            nxt_rdata[EW-1:0] = ev_stat_ff;
         end
         tamper_guard_pkg::OFS_EV_EN: begin
            nxt_rdata[EW-1:0] = ev_en_ff;
         end
         default: begin
            nxt_rdata = '0;
         end
      endcase
   end

   // read data stand for exactly the cycle after the strobe
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         rdata_o <= '0;
      end else if (rd_i) begin
         rdata_o <= nxt_rdata;
      end else begin
         rdata_o <= '0;
      end
   end
endmodule : jtag_tamper_guard

/* File: hdl/tamper_guard_pkg.sv */
// constants shared by the test-port tamper guard and its toggle detector
package tamper_guard_pkg;
   // register bus shape
   localparam int ADDR_W = 5;
   localparam int DATA_W = 32;
   // register byte offsets
   localparam logic [ADDR_W-1:0] OFS_GATE = 5'h00;     // gate control
   localparam logic [ADDR_W-1:0] OFS_FUSE = 5'h04;     // fuse program request
   localparam logic [ADDR_W-1:0] OFS_RESP = 5'h08;     // tamper response
   localparam logic [ADDR_W-1:0] OFS_STAT = 5'h0C;     // block status
   localparam logic [ADDR_W-1:0] OFS_EV_STAT = 5'h10;  // sticky events
   localparam logic [ADDR_W-1:0] OFS_EV_CLR = 5'h14;   // event clear, w1c
   localparam logic [ADDR_W-1:0] OFS_EV_EN = 5'h18;    // event enable
   localparam logic [ADDR_W-1:0] OFS_PEN = 5'h1C;      // software penalties
   // gate paths, one bit each in the gate register
   localparam int NUM_GATES = 4;
   localparam int GATE_TAP = 0;    // device test access port
   localparam int GATE_DAP = 1;    // processor debug access port
   localparam int GATE_USER = 2;   // user debug logic on the fabric
   localparam int GATE_CHAIN = 3;  // chain pass-through
   localparam logic [NUM_GATES-1:0] GATE_RST = 4'hF; // all blocking
   // fuse request register
   localparam int FUSE_PROG_BIT = 0;
   // response register fields
   localparam int RESP_W = 3;
   localparam int RESP_TRI_BIT = 0;   // tri-state all outputs
   localparam int RESP_RST_BIT = 1;   // restore fabric flip-flops
   localparam int RESP_IRQ_BIT = 2;   // stored only; interrupts come from the event enables
   localparam logic [RESP_W-1:0] RESP_RST = 3'h0;
   // software penalty register fields
   localparam int PEN_TRI_BIT = 0;
   localparam int PEN_RST_BIT = 1;
   // status register fields
   localparam int STAT_ALERT = 0;
   localparam int STAT_FUSE = 1;
   localparam int STAT_NONSEC = 2;
   localparam int STAT_TRI = 3;
   localparam int STAT_AUTH = 4;
   localparam int STAT_BOOT_DONE = 5;
   localparam int STAT_GATE_LSB = 8;
   // event bits
   localparam int EV_W = 3;
   localparam int EV_ALERT = 0;     // toggle alert raised
   localparam int EV_PENALTY = 1;   // a penalty was applied
   localparam int EV_REFUSED = 2;   // gate opening refused
   localparam logic [EV_W-1:0] EV_RST = 3'h0;
   // timing counts
   localparam int TOGGLE_EDGES = 3;     // qualifying tck edges to alert
   localparam int RESTORE_CYCLES = 16;  // flop restore pulse length
   localparam int BOOT_SETTLE = 4;      // cycles before strap capture
   // boot capture sequence
   typedef enum logic [1:0] {
      BOOT_WAIT,
      BOOT_SECURE,
      BOOT_NONSECURE
   } boot_state_t;
endpackage : tamper_guard_pkg

/* File: hdl/tck_toggle_detect.sv */
// test clock toggle detector with sticky alert
`timescale 1ns/1ps
module tck_toggle_detect #(
   parameter int EDGES = tamper_guard_pkg::TOGGLE_EDGES
) (
   input wire logic clk_i,
   input wire logic rst_n_i,   // power-on reset only
   input wire logic enable_i,  // low while any gate is open
   input wire logic tck_i,
   input wire logic tdi_i,
   input wire logic tms_i,
   output logic tck_s_o,       // synchronised pins, reused by the parent
   output logic tdi_s_o,
   output logic tms_s_o,
   output logic alert_o
);
   localparam int CNT_W = $clog2(EDGES + 1);
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(EDGES - 1);

   logic [2:0] meta_ff;       // first synchroniser stage, read by stage two
   logic tck_prev_ff;         // previous synchronised tck for edge finding
   logic [CNT_W-1:0] cnt_ff;  // consecutive qualifying edges
   logic tck_rise;

   // two-flop synchronisers on the pins
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         meta_ff <= 3'h0;
         tck_s_o <= 1'b0;
         tdi_s_o <= 1'b0;
         tms_s_o <= 1'b0;
         tck_prev_ff <= 1'b0;
      end else begin
         meta_ff <= {tck_i, tdi_i, tms_i};
         tck_s_o <= meta_ff[2];
         tdi_s_o <= meta_ff[1];
         tms_s_o <= meta_ff[0];
         tck_prev_ff <= tck_s_o;
      end
   end

   assign tck_rise = tck_s_o & ~tck_prev_ff;

   // count rising edges while tdi or tms is high; a quiet edge restarts
   always_ff @(posedge clk_i) begin
      if (!rst_n_i || !enable_i) begin
         cnt_ff <= '0; // held idle while debug is open
      end else if (tck_rise) begin
         if (!(tdi_s_o || tms_s_o)) begin
            cnt_ff <= '0;
         end else if (cnt_ff != CNT_LAST + CNT_W'(1)) begin
            cnt_ff <= cnt_ff + CNT_W'(1);
         end
      end
   end

   // alert after the third qualifying edge; only power-on reset clears it
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         alert_o <= 1'b0;
      end else if (enable_i && tck_rise && (tdi_s_o || tms_s_o)
                   && cnt_ff == CNT_LAST) begin
         alert_o <= 1'b1;
      end
   end
endmodule : tck_toggle_detect

/* File: tb/jtag_tamper_guard_assertions.sv */
// port-level checks for the test-port tamper guard
`timescale 1ns/1ps
module jtag_tamper_guard_checker #(
   parameter int NUM_GATES = 4,
   parameter int RESTORE_CYCLES = 16
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [tamper_guard_pkg::DATA_W-1:0] rdata_o,
   input wire logic sw_auth_i,
   input wire logic boot_nonsec_i,
   input wire logic fuse_disable_i,
   input wire logic [NUM_GATES-1:0] path_open_o,
   input wire logic user_tck_o,
   input wire logic user_tms_o,
   input wire logic user_tdi_o,
   input wire logic ir_force_bypass_o,
   input wire logic fuse_prog_o,
   input wire logic global_output_tristate_o,
   input wire logic global_flop_restore_o,
   input wire logic alert_o
);
   // length of the current restore pulse, so any pulse length is checkable
   logic [15:0] run_ff;
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         run_ff <= 16'h0;
      end else if (global_flop_restore_o) begin
         run_ff <= run_ff + 16'h1;
      end else begin
         run_ff <= 16'h0;
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   AST_RDATA_IDLE: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
      else $error("read data seen without a read");
   AST_ALERT_STICKY: assert property (alert_o |=> alert_o)
      else $error("alert dropped before power-on reset");
   AST_ALERT_HELD: assert property (
      (|path_open_o)[*8] |=> !$rose(alert_o))
      else $error("alert raised while a gate was open");
   AST_TRI_STICKY: assert property (
      global_output_tristate_o |=> global_output_tristate_o)
      else $error("output tri-state released");
   AST_TRI_CAUSE: assert property ($rose(global_output_tristate_o) |->
      alert_o || $past(wr_i) || $past(wr_i, 2) || $past(wr_i, 3))
      else $error("tri-state without alert or write");
   AST_RESTORE_LEN: assert property (
      $fell(global_flop_restore_o) |-> run_ff == RESTORE_CYCLES)
      else $error("restore pulse has wrong length");
   AST_FUSE_BYPASS: assert property (
      fuse_disable_i[*4] |=> ir_force_bypass_o)
      else $error("bypass not forced with fuse blown");
   AST_FUSE_CLOSED: assert property (
      ir_force_bypass_o[*3] |-> path_open_o == '0)
      else $error("gate open with fuse blown");
   AST_USER_CUT: assert property (
      (!(path_open_o[2] && path_open_o[3]))[*2] |->
      !user_tck_o && !user_tms_o && !user_tdi_o)
      else $error("user debug pins live while gated");
   AST_OPEN_AUTH: assert property ($rose(|path_open_o) |->
      boot_nonsec_i || $past(sw_auth_i, 2))
      else $error("gate opened without unlock");
   AST_FUSE_PULSE: assert property (fuse_prog_o |->
      ($past(wr_i) || $past(wr_i, 2)) ##1 !fuse_prog_o)
      else $error("fuse program pulse malformed");
   cover property ($rose(alert_o));
   cover property ($rose(global_flop_restore_o));
   cover property ($rose(|path_open_o));
endmodule : jtag_tamper_guard_checker

bind jtag_tamper_guard jtag_tamper_guard_checker #(
   .NUM_GATES(NUM_GATES),
   .RESTORE_CYCLES(RESTORE_CYCLES)
) chk_u (
   .clk_i(clk_i), .rst_n_i(rst_n_i), .wr_i(wr_i), .rd_i(rd_i),
   .rdata_o(rdata_o), .sw_auth_i(sw_auth_i),
   .boot_nonsec_i(boot_nonsec_i), .fuse_disable_i(fuse_disable_i),
   .path_open_o(path_open_o), .user_tck_o(user_tck_o),
   .user_tms_o(user_tms_o), .user_tdi_o(user_tdi_o),
   .ir_force_bypass_o(ir_force_bypass_o), .fuse_prog_o(fuse_prog_o),
   .global_output_tristate_o(global_output_tristate_o),
   .global_flop_restore_o(global_flop_restore_o), .alert_o(alert_o)
);

/* File: tb/jtag_host_model.sv */
// external debugger model driving the test port pins
`timescale 1ns/1ps
module jtag_host_model (
   output logic tck_o,
   output logic tms_o,
   output logic tdi_o
);
   // idle: clock parked low, data pins at their pull-up level
   initial begin
      tck_o = 1'b0;
      tms_o = 1'b1;
      tdi_o = 1'b1;
   end
   // n test clocks at 125 ns with fixed pin levels, then release
   task automatic frame(input int n, input logic tms_v, input logic tdi_v);
      #1;
      tms_o = tms_v;
      tdi_o = tdi_v;
      repeat (n) begin
         #62.5 tck_o = 1'b1;
         #62.5 tck_o = 1'b0;
      end
      #62.5;
      tms_o = 1'b1;
      tdi_o = 1'b1;
   endtask : frame
endmodule : jtag_host_model

/* File: tb/tb_top.sv */
// self-checking bench for the test-port tamper guard
`timescale 1ns/1ps
module tb_top;
   localparam int RC = 4;  // short restore pulse keeps the run brief
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [4:0] addr_i = 5'h00;
   logic [31:0] wdata_i = 32'h0;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [31:0] rdata_o;
   logic sw_auth_i = 1'b0;
   logic boot_nonsec_i = 1'b0;
   logic fuse_disable_i = 1'b0;
   logic tck, tms, tdi;
   logic [3:0] path_open_o;
   logic user_tck_o, user_tms_o, user_tdi_o;
   logic ir_force_bypass_o, fuse_prog_o, alert_o, irq_o;
   logic global_output_tristate_o, global_flop_restore_o;
   int fail_count = 0;
   int compares = 0;
   int cyc = 0;
   int fp_n = 0;  // fuse program pulses seen
   int rs_n = 0;  // restore cycles seen
   int ut_n = 0;  // cycles with the forwarded test clock high
   jtag_tamper_guard #(.RESTORE_CYCLES(RC)) dut_u (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .sw_auth_i(sw_auth_i), .boot_nonsec_i(boot_nonsec_i),
      .fuse_disable_i(fuse_disable_i), .tck_i(tck), .tms_i(tms),
      .tdi_i(tdi), .path_open_o(path_open_o), .user_tck_o(user_tck_o),
      .user_tms_o(user_tms_o), .user_tdi_o(user_tdi_o),
      .ir_force_bypass_o(ir_force_bypass_o), .fuse_prog_o(fuse_prog_o),
      .global_output_tristate_o(global_output_tristate_o),
      .global_flop_restore_o(global_flop_restore_o),
      .alert_o(alert_o), .irq_o(irq_o));
   jtag_host_model host_u (.tck_o(tck), .tms_o(tms), .tdi_o(tdi));
   // 200 MHz clock
   initial begin
      forever #2.5 clk_i = ~clk_i;
   end
   task automatic test_done();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : test_done
   // pulse counters and hang guard
   always @(posedge clk_i) begin
      cyc++;
      if (fuse_prog_o === 1'b1) fp_n++;
      if (global_flop_restore_o === 1'b1) rs_n++;
      if (user_tck_o === 1'b1) ut_n++;
      if (cyc == 20000) begin
         fail_count++;
         $display("ERROR %0t run timed out", $time);
         test_done();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic settle(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : settle
   // one-cycle write strobe
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask : wr
   // one-cycle read strobe, data taken in the following cycle
   task automatic rchk(input logic [4:0] a, input logic [31:0] exp);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1;
      chk(rdata_o, exp);
   endtask : rchk
   // power-on reset, then let boot capture finish
   task automatic por();
      @(posedge clk_i);
      rst_n_i <= 1'b0;
      repeat (20) @(posedge clk_i);
      rst_n_i <= 1'b1;
      settle(14);
   endtask : por
   initial begin
      por();
      chk(path_open_o, 4'h0);
      rchk(tamper_guard_pkg::OFS_GATE, 32'hF);
      rchk(tamper_guard_pkg::OFS_RESP, 32'h0);
      rchk(tamper_guard_pkg::OFS_EV_EN, 32'h0);
      wr(5'h02, 32'hFFFFFFFF);
      rchk(5'h02, 32'h0);
      // opening without authentication is refused and logged
      wr(tamper_guard_pkg::OFS_GATE, 32'h0);
      rchk(tamper_guard_pkg::OFS_GATE, 32'hF);
      rchk(tamper_guard_pkg::OFS_EV_STAT, 32'h4);
      wr(tamper_guard_pkg::OFS_EV_EN, 32'h4);
      settle(3);
      chk(irq_o, 1'b1);
      wr(tamper_guard_pkg::OFS_EV_EN, 32'h0);
      settle(3);
      chk(irq_o, 1'b0);
      wr(tamper_guard_pkg::OFS_EV_EN, 32'h4);
      wr(tamper_guard_pkg::OFS_EV_CLR, 32'h4);
      settle(3);
      chk(irq_o, 1'b0);
      rchk(tamper_guard_pkg::OFS_EV_STAT, 32'h0);
      // two active edges, a quiet edge, two more: count restarts
      host_u.frame(2, 1'b1, 1'b0);
      host_u.frame(1, 1'b0, 1'b0);
      host_u.frame(2, 1'b0, 1'b1);
      settle(8);
      chk(alert_o, 1'b0);
      host_u.frame(1, 1'b1, 1'b1);
      settle(8);
      chk(alert_o, 1'b1);
      rchk(tamper_guard_pkg::OFS_STAT, 32'hF21);
      chk(global_output_tristate_o, 1'b0);
      chk(rs_n, 0);
      wr(tamper_guard_pkg::OFS_RESP, 32'h1);
      settle(3);
      chk(global_output_tristate_o, 1'b1);
      wr(tamper_guard_pkg::OFS_EV_CLR, 32'h7);
      rchk(tamper_guard_pkg::OFS_STAT, 32'hF29);
      wr(tamper_guard_pkg::OFS_PEN, 32'h2);
      settle(3 * RC);
      chk(rs_n, RC);
      por();
      chk(alert_o, 1'b0);
      chk(global_output_tristate_o, 1'b0);
      // authenticated software opens the port; detector held idle
      @(posedge clk_i);
      sw_auth_i <= 1'b1;
      wr(tamper_guard_pkg::OFS_GATE, 32'h0);
      settle(2);
      chk(path_open_o, 4'hF);
      chk({user_tms_o, user_tdi_o}, 2'h3);
      ut_n = 0;
      host_u.frame(4, 1'b1, 1'b1);
      settle(8);
      chk(alert_o, 1'b0);
      chk(ut_n != 0, 1'b1);
      wr(tamper_guard_pkg::OFS_GATE, 32'h4);
      settle(2);
      chk(path_open_o, 4'hB);
      chk({user_tms_o, user_tdi_o}, 2'h0);
      // restore configured as the response to a fresh alert
      wr(tamper_guard_pkg::OFS_RESP, 32'h2);
      wr(tamper_guard_pkg::OFS_GATE, 32'hF);
      ut_n = 0;
      rs_n = 0;
      host_u.frame(3, 1'b1, 1'b0);
      settle(8);
      chk(alert_o, 1'b1);
      chk(rs_n, RC);
      chk(ut_n, 0);
      chk(global_output_tristate_o, 1'b0);
      // blown fuse forces bypass and keeps every gate shut
      @(posedge clk_i);
      fuse_disable_i <= 1'b1;
      settle(8);
      chk(ir_force_bypass_o, 1'b1);
      wr(tamper_guard_pkg::OFS_GATE, 32'h0);
      rchk(tamper_guard_pkg::OFS_GATE, 32'hF);
      fp_n = 0;
      wr(tamper_guard_pkg::OFS_FUSE, 32'h1);
      settle(4);
      chk(fp_n, 1);
      // non-secure boot opens the port on its own
      @(posedge clk_i);
      fuse_disable_i <= 1'b0;
      sw_auth_i <= 1'b0;
      boot_nonsec_i <= 1'b1;
      por();
      chk(path_open_o, 4'hF);
      test_done();
   end
endmodule : tb_top
